// >>> core/ocp_pkg.sv
// Purpose: Shared constants and types for the compare/PWM channel
// Assumes: 16-bit registers on a plain strobe port
// Notes:   Offsets are byte addresses on a 4-bit address
package ocp_pkg;
	// ---------------------------------------------
	// Widths
	// ---------------------------------------------
	localparam int unsigned DW = 16;
	localparam int unsigned AW = 4;

	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [AW-1:0] OFS_SEC   = 4'h0;
	localparam logic [AW-1:0] OFS_MAIN  = 4'h2;
	localparam logic [AW-1:0] OFS_CTRL  = 4'h4;
	localparam logic [AW-1:0] OFS_STAT  = 4'h6;
	localparam logic [AW-1:0] OFS_CLR   = 4'h8;
	localparam logic [AW-1:0] OFS_EN    = 4'hA;

	// ---------------------------------------------
	// Control field positions
	// ---------------------------------------------
	localparam int unsigned CTL_MODE_LO = 0;
	localparam int unsigned CTL_TSEL    = 3;
	localparam int unsigned CTL_FAULT   = 4;
	localparam int unsigned CTL_SIDL    = 13;

	// ---------------------------------------------
	// Status bit positions and reset values
	// ---------------------------------------------
	localparam int unsigned ST_CMP  = 0;
	localparam int unsigned ST_TA   = 1;
	localparam int unsigned ST_TB   = 2;
	localparam int unsigned ST_FLT  = 3;
	localparam int unsigned ST_W    = 4;
	localparam logic [DW-1:0] RST_VAL = 16'h0000;

	// Mode codes of the compare_mode_field
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_LOW,
		MODE_HIGH,
		MODE_TOGGLE,
		MODE_ONE_PULSE,
		MODE_PULSES,
		MODE_PWM,
		MODE_PWM_FLT
	} ocp_mode_e;

	// One timer as seen by the channel
	typedef struct packed {
		logic [DW-1:0] count;
		logic [DW-1:0] period;
		logic          run;
		logic          sidl;
	} ocp_tmr_s;
endpackage

// >>> core/ocp_channel.sv
// Purpose: One output compare channel with pulse and PWM modes
// Assumes: Timers live outside; counts change on core_clk_i edges
// Notes:   Pin is two signals; enable low means high impedance
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Modes 001/010/011 drive low, high, toggle
// - Single compare uses main value against count
// - Wrap before match leaves pin alone
// - Modes 100/101 pulse start main, end secondary
// - Writing mode 100 arms exactly one pulse
// - PWM modes: main read-only, duty via secondary
// - Mode 111 fault low tristates, sets fault bit
// - Fault holds until input high and mode rewritten
// - PWM period set by timer period register
// - Period wrap: pin high, latch duty, timer flag
// - Duty zero stays low, above period stays high
// - Sleep holds pin level, resumes on wake
// - Idle runs only when both stop bits clear
// - Non-PWM compare events set sticky flag
// - PWM never sets compare flag, uses timer flag
// - Control bit 3 picks timer, first after reset
module ocp_channel
	import ocp_pkg::*;
(
	// Clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          rst_i,
	// Register port
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [DW-1:0] rdata_o,
	// Timers
	input  wire ocp_tmr_s      timer_a_i,
	input  wire ocp_tmr_s      timer_b_i,
	// Power state
	input  wire logic          sleep_i,
	input  wire logic          idle_i,
	// Fault input, active low
	input  wire logic          fault_n_i,
	// Compare output pin
	output logic               pin_o,
	output logic               pin_oe_o,
	// Events and interrupt
	output logic               tmr_a_flag_set_o,
	output logic               tmr_b_flag_set_o,
	output logic               irq_o
);
	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	// True for either PWM code
	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = (m == MODE_PWM) || (m == MODE_PWM_FLT);
	endfunction

	// New count equal to a compare value
	function automatic logic hit(input logic fresh, input logic [DW-1:0] c, input logic [DW-1:0] v);
		hit = fresh && (c == v);
	endfunction

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	logic [DW-1:0] sec_val;     // Secondary compare value
	logic [DW-1:0] main_val;    // Main compare value
	ocp_mode_e     mode;        // Compare mode field
	logic          tsel;        // Time base select
	logic          sidl;        // Channel stop in idle
	logic          fault;       // Fault status bit
	logic          armed;       // One pulse pending
	logic          pin;         // Pin level
	logic [DW-1:0] prev_a;      // Last count of timer A
	logic [DW-1:0] prev_b;      // Last count of timer B
	logic [ST_W-1:0] stat;      // Sticky event bits
	logic [ST_W-1:0] ien;       // Event enables
	logic [DW-1:0] rdata;       // Read data flop
	logic [DW-1:0] rd_mux;      // Read mux output
	logic          ta_set;      // Timer A flag pulse
	logic          tb_set;      // Timer B flag pulse

	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	wire wr_sec  = wr_i && (addr_i == OFS_SEC);
	wire wr_main = wr_i && (addr_i == OFS_MAIN);
	wire wr_ctrl = wr_i && (addr_i == OFS_CTRL);
	wire wr_clr  = wr_i && (addr_i == OFS_CLR);
	wire wr_en   = wr_i && (addr_i == OFS_EN);
	wire [2:0] wmode = wdata_i[CTL_MODE_LO +: 3];

	wire ocp_tmr_s tm = tsel ? timer_b_i : timer_a_i;
	wire [DW-1:0] prev = tsel ? prev_b : prev_a;

	// A count that moved since the last edge
	wire fresh = (tm.count != prev);
	wire wrap  = fresh && (prev == tm.period);

	wire run_ok = !sleep_i && (!idle_i || (!sidl && tm.run && !tm.sidl));

	wire m_main = run_ok && hit(fresh, tm.count, main_val);
	wire m_sec  = run_ok && hit(fresh, tm.count, sec_val);
	wire pwm    = is_pwm(mode);

	wire cmp_evt = run_ok && !pwm && (mode != MODE_OFF)
	               && (m_main || (m_sec && (mode == MODE_ONE_PULSE || mode == MODE_PULSES)));
	wire per_evt = run_ok && pwm && wrap;

	// fault sampled only in mode 111
	wire flt_set = (mode == MODE_PWM_FLT) && !fault_n_i;
	// clear needs input high and PWM rewrite
	wire flt_clr = wr_ctrl && is_pwm(wmode) && fault_n_i;

	wire [ST_W-1:0] ev = {flt_set, per_evt && tsel, per_evt && !tsel, cmp_evt};

	// ---------------------------------------------
	// Next pin level
	// ---------------------------------------------
	logic next_pin;
	logic next_armed;
	always_comb
	begin
		next_pin   = pin;
		next_armed = armed;
		if (!run_ok)
		begin
			next_pin = pin;
		end
		else
		begin
			case (mode)
				MODE_OFF:
					next_pin = 1'b0;
				MODE_LOW:
					if (m_main) next_pin = 1'b0;
				MODE_HIGH:
					if (m_main) next_pin = 1'b1;
				MODE_TOGGLE:
					if (m_main) next_pin = !pin;
				MODE_ONE_PULSE:
				begin
					if (armed && m_main)
						next_pin = 1'b1;
					else if (armed && pin && m_sec)
					begin
						next_pin   = 1'b0;
						next_armed = 1'b0;
					end
				end
				MODE_PULSES:
				begin
					if (m_main)
						next_pin = 1'b1;
					else if (m_sec)
						next_pin = 1'b0;
				end
				MODE_PWM, MODE_PWM_FLT:
				begin
					if (wrap)
						next_pin = (sec_val != 16'h0000);
					else if (m_main)
						next_pin = 1'b0;
				end
				default:
					next_pin = 1'b0;
			endcase
		end
		// A fresh arm beats a pulse ending in the same cycle
		if (wr_ctrl && wmode == MODE_ONE_PULSE)
			next_armed = 1'b1;
	end

	// ---------------------------------------------
	// Registers written by software
	// ---------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			sec_val <= RST_VAL;
			mode    <= MODE_OFF;
			tsel    <= 1'b0;
			sidl    <= 1'b0;
			ien     <= '0;
		end
		else
		begin
			if (wr_sec)
				sec_val <= wdata_i;
			if (wr_ctrl)
			begin
				mode <= ocp_mode_e'(wmode);
				tsel <= wdata_i[CTL_TSEL];
				sidl <= wdata_i[CTL_SIDL];
			end
			if (wr_en)
				ien <= wdata_i[ST_W-1:0];
		end
	end

	// Main value: software write, or duty latch at wrap
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			main_val <= RST_VAL;
		else if (per_evt)
			main_val <= sec_val;
		else if (wr_main && !pwm)
			main_val <= wdata_i;
	end

	// ---------------------------------------------
	// Channel state
	// ---------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			pin    <= 1'b0;
			armed  <= 1'b0;
			fault  <= 1'b0;
			prev_a <= RST_VAL;
			prev_b <= RST_VAL;
		end
		else
		begin
			pin    <= next_pin;
			armed  <= next_armed;
			prev_a <= timer_a_i.count;
			prev_b <= timer_b_i.count;
			if (flt_set)
				fault <= 1'b1;
			else if (flt_clr)
				fault <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Interrupt status
	// ---------------------------------------------
	// Sticky bits: an event in the clear cycle survives
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			stat <= '0;
		else if (wr_clr)
			stat <= (stat & ~wdata_i[ST_W-1:0]) | ev;
		else
			stat <= stat | ev;
	end

	// Timer flag pulses and read data
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			ta_set <= 1'b0;
			tb_set <= 1'b0;
			rdata  <= RST_VAL;
		end
		else
		begin
			ta_set <= per_evt && !tsel;
			tb_set <= per_evt && tsel;
			rdata  <= rd_i ? rd_mux : RST_VAL;
		end
	end

	// ---------------------------------------------
	// Read mux
	// ---------------------------------------------
	logic [DW-1:0] ctl_word;
	always_comb
	begin
		ctl_word = RST_VAL;
		ctl_word[CTL_MODE_LO +: 3] = mode;
		ctl_word[CTL_TSEL]  = tsel;
		ctl_word[CTL_FAULT] = fault;
		ctl_word[CTL_SIDL]  = sidl;
		case (addr_i)
			OFS_SEC:  rd_mux = sec_val;
			OFS_MAIN: rd_mux = main_val;
			OFS_CTRL: rd_mux = ctl_word;
			OFS_STAT: rd_mux = {{(DW-ST_W){1'b0}}, stat};
			OFS_EN:   rd_mux = {{(DW-ST_W){1'b0}}, ien};
			// Clear register and holes read zero
			default:  rd_mux = RST_VAL;
		endcase
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign rdata_o          = rdata;
	assign pin_o            = pin;
	assign pin_oe_o         = !fault;
	assign tmr_a_flag_set_o = ta_set;
	assign tmr_b_flag_set_o = tb_set;
	// level while an enabled bit is set
	assign irq_o            = |(stat & ien);

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	AST_OFF_LOW: assert property (
		run_ok && mode == MODE_OFF |=> !pin_o)
		else $error("disabled channel pin not low");
	AST_FORCE_LOW: assert property (
		m_main && mode == MODE_LOW |=> !pin_o)
		else $error("force low match ignored");
	AST_FORCE_HIGH: assert property (
		m_main && mode == MODE_HIGH |=> pin_o)
		else $error("force high match ignored");
	AST_TOGGLE: assert property (
		m_main && mode == MODE_TOGGLE |=> pin_o != $past(pin_o))
		else $error("toggle match ignored");
	AST_NO_MATCH_HOLD: assert property (
		run_ok && mode inside {MODE_LOW, MODE_HIGH, MODE_TOGGLE} && !m_main |=> $stable(pin_o))
		else $error("pin moved without match");
	AST_SLEEP_HOLD: assert property (
		sleep_i |=> $stable(pin_o))
		else $error("pin moved in sleep");
	AST_PWM_LATCH: assert property (
		per_evt |=> main_val == $past(sec_val) && tmr_a_flag_set_o != tmr_b_flag_set_o)
		else $error("duty not latched at wrap");
	AST_PWM_NO_CMP: assert property (
		pwm && !stat[ST_CMP] |=> !stat[ST_CMP])
		else $error("compare flag set in PWM");
	AST_CMP_FLAG: assert property (
		cmp_evt |=> stat[ST_CMP] ##1 (stat[ST_CMP] || $past(wr_clr)))
		else $error("compare flag not set");
	AST_FAULT: assert property (
		flt_set |=> !pin_oe_o && fault)
		else $error("fault did not tristate");
	AST_FAULT_HOLD: assert property (
		fault && !flt_clr |=> !pin_oe_o)
		else $error("fault released without rewrite");
	AST_MAIN_RO: assert property (
		pwm && wr_main && !per_evt |=> $stable(main_val))
		else $error("main value written in PWM");
	AST_IDLE_HOLD: assert property (
		idle_i && sidl |=> $stable(pin_o))
		else $error("pin moved in stopped idle");
	AST_DUTY_ZERO: assert property (
		per_evt && sec_val == 16'h0000 |=> !pin_o)
		else $error("zero duty pin not low");

	COV_PWM_WRAP: cover property (per_evt ##[1:50] m_main);
	COV_TRAIN: cover property (mode == MODE_PULSES && m_sec ##1 !pin_o);
	COV_ONE_PULSE: cover property (armed && m_main ##[1:50] !armed);
	COV_FAULT_CLR: cover property (flt_set ##[1:50] flt_clr);
endmodule

// >>> tb/ocp_load.sv
// Purpose: Load on the compare pin, gives the wire level
// Assumes: No pull resistor on the pin
// Notes:   A released wire wanders every cycle
`timescale 1ns/1ps
module ocp_load
(
	// Clock
	input  wire logic core_clk_i,
	// Pin from the channel
	input  wire logic pin_i,
	input  wire logic pin_oe_i,
	// Level seen on the wire
	output logic      line_o
);
	// ---------------------------------------------
	// Wire level
	// ---------------------------------------------
	logic last = 1'b0; // Last level, or wander state
	// Floating wire must not look like a held level
	always @(posedge core_clk_i)
	begin
		if (pin_oe_i)
			last <= pin_i;
		else
			last <= ~last;
	end
	assign line_o = pin_oe_i ? pin_i : ~last;
endmodule

// >>> tb/output_compare_pwm_channel_tb.sv
// Purpose: Self-checking bench of the compare channel
// Assumes: Timers modelled here, period 20
// Notes:   Widths counted as high cycles on the wire
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module output_compare_pwm_channel_tb;
	import ocp_pkg::*;
	logic          clk, rst, wr, rd, slp, idl, flt_n; // Drives
	logic [AW-1:0] addr;                              // Offset
	logic [DW-1:0] wd, rdata, d;                      // Data
	ocp_tmr_s      ta, tb_t;                          // Timers
	logic          pin, oe, fa, fb, irq, line;        // Outputs
	int            errors, total_checks, hi, na, nb, h, a, b, i;
	ocp_mode_e     m;
	ocp_channel dut_u (.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wd),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_a_i(ta), .timer_b_i(tb_t),
		.sleep_i(slp), .idle_i(idl), .fault_n_i(flt_n), .pin_o(pin), .pin_oe_o(oe),
		.tmr_a_flag_set_o(fa), .tmr_b_flag_set_o(fb), .irq_o(irq));
	ocp_load load_u (.core_clk_i(clk), .pin_i(pin), .pin_oe_i(oe), .line_o(line));
	// ---------------------------------------------
	// Clock, timers, counters
	// ---------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Stopped timers read zero; all freeze in sleep
	always @(posedge clk)
	begin
		ta.count <= !ta.run ? 16'h0000 : slp ? ta.count : ta.count == ta.period ? 16'h0000 : ta.count + 1;
		tb_t.count <= !tb_t.run ? 16'h0000 : slp ? tb_t.count : tb_t.count == tb_t.period ? 16'h0000
			: tb_t.count + 1;
		hi <= hi + int'(line === 1'b1);
		na <= na + int'(fa === 1'b1);
		nb <= nb + int'(fb === 1'b1);
	end
	// ---------------------------------------------
	// Bus and span tasks
	// ---------------------------------------------
	task automatic wrt(input logic [AW-1:0] o, input logic [DW-1:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= o;
		wd <= v;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rdt(input logic [AW-1:0] o, output logic [DW-1:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= o;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// Counts high wire cycles and flag pulses over n cycles
	task automatic span(input int n);
		int h0, a0, b0;
		h0 = hi;
		a0 = na;
		b0 = nb;
		repeat (n) @(posedge clk);
		#1;
		h = hi - h0;
		a = na - a0;
		b = nb - b0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog, far beyond the sequence length
	initial
	begin
		#60000;
		errors++;
		report_and_stop();
	end
	// ---------------------------------------------
	// Sequence
	// ---------------------------------------------
	initial
	begin
		{rst, wr, rd, slp, idl, addr, wd} = '0;
		flt_n = 1'b1;
		{hi, na, nb, errors, total_checks} = '0;
		ta = '{count: 16'h0000, period: 16'h0014, run: 1'b0, sidl: 1'b0};
		tb_t = ta;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdt(OFS_CTRL, d);
		`CHK("ctrl", 16'h0000, d)
		`CHK("pin", 2'b01, {pin, oe})
		rdt(4'hC, d);
		`CHK("unmapped", 16'h0000, d)
		// Single compare modes, free-running timer
		wrt(OFS_MAIN, 16'h0005);
		ta.run <= 1'b1;
		for (i = 0; i < 3; i++)
		begin
			m = i == 0 ? MODE_HIGH : i == 1 ? MODE_LOW : MODE_TOGGLE;
			wrt(OFS_CTRL, 16'(m));
			span(21);
			`CHK("single", i != 1, pin)
		end
		span(21);
		`CHK("toggle", 1'b0, pin)
		wrt(OFS_MAIN, 16'h001E);
		span(42);
		`CHK("wrap", 1'b0, pin)
		wrt(OFS_EN, 16'h0001);
		`CHK("irq", 1'b1, irq)
		wrt(OFS_CTRL, 16'h0000);
		span(3);
		`CHK("off", 2'b01, {pin, oe})
		wrt(OFS_EN, 16'h0000);
		`CHK("mask", 1'b0, irq)
		wrt(OFS_EN, 16'h0001);
		wrt(OFS_CLR, 16'h001F);
		`CHK("clear", 1'b0, irq)
		// PWM, duty 6 of 21
		wrt(OFS_SEC, 16'h0006);
		wrt(OFS_CTRL, 16'(MODE_PWM));
		span(42);
		wrt(OFS_MAIN, 16'h0003);
		wrt(OFS_CLR, 16'h001F);
		span(42);
		`CHK("duty", 12, h)
		`CHK("tflag", 2, a)
		rdt(OFS_MAIN, d);
		`CHK("main", 16'h0006, d)
		rdt(OFS_STAT, d);
		`CHK("cmpflag", 1'b0, d[ST_CMP])
		for (i = 0; i < 2; i++)
		begin
			wrt(OFS_SEC, i ? 16'h0019 : 16'h0000);
			span(42);
			span(42);
			`CHK("edge", i ? 42 : 0, h)
		end
		wrt(OFS_SEC, 16'h0006);
		span(42);
		slp <= 1'b1;
		span(2);
		d[0] = pin;
		span(42);
		`CHK("sleep", d[0] ? 44 : 0, h + (d[0] ? 2 : 0))
		slp <= 1'b0;
		idl <= 1'b1;
		wrt(OFS_CTRL, 16'h2006);
		span(42);
		d[0] = pin;
		span(42);
		`CHK("idlestop", d[0] ? 42 : 0, h)
		wrt(OFS_CTRL, 16'(MODE_PWM));
		span(21);
		span(42);
		`CHK("idlerun", 12, h)
		idl <= 1'b0;
		tb_t.run <= 1'b1;
		wrt(OFS_CTRL, 16'h000E);
		span(42);
		span(42);
		`CHK("tsel", 12, h)
		`CHK("tflagb", 2, b)
		// Fault protection
		wrt(OFS_CTRL, 16'(MODE_PWM_FLT));
		flt_n <= 1'b0;
		span(3);
		`CHK("fault", 1'b0, oe)
		rdt(OFS_CTRL, d);
		`CHK("fltbit", 1'b1, d[CTL_FAULT])
		flt_n <= 1'b1;
		span(5);
		`CHK("hold", 1'b0, oe)
		wrt(OFS_CTRL, 16'(MODE_PWM_FLT));
		span(3);
		`CHK("resume", 1'b1, oe)
		// Pulse modes, configured before the timer runs
		wrt(OFS_CTRL, 16'h0000);
		ta.run <= 1'b0;
		wrt(OFS_MAIN, 16'h0004);
		wrt(OFS_SEC, 16'h0008);
		wrt(OFS_CTRL, 16'(MODE_ONE_PULSE));
		ta.run <= 1'b1;
		span(63);
		`CHK("pulse", 4, h)
		wrt(OFS_CTRL, 16'(MODE_ONE_PULSE));
		span(63);
		`CHK("rearm", 4, h)
		wrt(OFS_CTRL, 16'(MODE_PULSES));
		span(21);
		span(42);
		`CHK("train", 8, h)
		report_and_stop();
	end
endmodule
